/* tb_tmrps_top.sv */
/* Self-checking bench for tmrps_top over AXI4-Lite.
   Assumes the pin source model and the bound port checker. */
`timescale 1ns/1ps
module tb_tmrps_top import tmrps_pkg::*;;
    logic ref_clk_in = 1'h0, nrst_in = 1'h0, awvalid_in = 1'h0, wvalid_in = 1'h0;
    logic bready_in = 1'h0, arvalid_in = 1'h0, rready_in = 1'h0, sleep_in = 1'h0;
    logic clear_watchdog_in = 1'h0, watchdog_base_tick_in = 1'h0, count_input_pin_in;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic watchdog_tick_out, overflow_irq_out, pin_go = 1'h0;
    logic [4:0] awaddr_in = 5'h00, araddr_in = 5'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out;
    logic [3:0] wstrb_in = 4'hf, pin_toggles = 4'h0;
    logic [1:0] bresp_out, rresp_out;
    int n_errors = 0, checked = 0, cyc = 0;

    tmrps_top tmrps_top_inst (.*);
    tmrps_pin_src tmrps_pin_src_inst (.ref_clk_in(ref_clk_in), .go_in(pin_go),
        .toggles_in(pin_toggles), .pin_out(count_input_pin_in));

    always #25 ref_clk_in = ~ref_clk_in;

    // Hang guard, well above the longest run
    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("%0d checks, %0d mismatches", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string w);
        checked = checked + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %s got %h", $time, w, seen);
        end
    endtask

    // Bus master: valids held until taken, answer awaited
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr_in <= a;
        wdata_in <= {24'h0, d};
        awvalid_in <= 1'h1;
        wvalid_in <= 1'h1;
        bready_in <= 1'h1;
        do
        begin
            @(posedge ref_clk_in);
            if (awready_out === 1'h1) awvalid_in <= 1'h0;
            if (wready_out === 1'h1) wvalid_in <= 1'h0;
        end
        while (bvalid_out !== 1'h1);
        bready_in <= 1'h0;
        check({30'h0, bresp_out}, {30'h0, er}, "bresp");
        // Idle edge so a following call never reassigns bready in this step
        @(posedge ref_clk_in);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        araddr_in <= a;
        arvalid_in <= 1'h1;
        rready_in <= 1'h1;
        do
        begin
            @(posedge ref_clk_in);
            if (arready_out === 1'h1) arvalid_in <= 1'h0;
        end
        while (rvalid_out !== 1'h1);
        rready_in <= 1'h0;
        check({30'h0, rresp_out}, {30'h0, er}, "rresp");
        check(rdata_out, {24'h0, d}, "rdata");
        // Idle edge so a following call never reassigns rready in this step
        @(posedge ref_clk_in);
    endtask

    // Counts cycles from the count write to the interrupt request
    task automatic run_timer(input logic [7:0] opt, input logic [7:0] st,
        input int lo, input int hi);
        int n;
        wr(TMRPS_OFS_OPTION, opt, TMRPS_RESP_OKAY);
        wr(TMRPS_OFS_INTCTL, 8'h20, TMRPS_RESP_OKAY);
        wr(TMRPS_OFS_COUNT, st, TMRPS_RESP_OKAY);
        n = 0;
        while (overflow_irq_out !== 1'h1 && n <= hi)
        begin
            @(posedge ref_clk_in);
            n = n + 1;
        end
        check({31'h0, n >= lo && n <= hi}, 32'h1, "overflow time");
    endtask

    task automatic pulses(input logic [3:0] n);
        pin_toggles <= n;
        pin_go <= 1'h1;
        @(posedge ref_clk_in);
        pin_go <= 1'h0;
        repeat (8 * n + 16) @(posedge ref_clk_in);
    endtask

    task automatic clr_wdt();
        clear_watchdog_in <= 1'h1;
        @(posedge ref_clk_in);
        clear_watchdog_in <= 1'h0;
    endtask

    task automatic wd_tick(input logic exp);
        watchdog_base_tick_in <= 1'h1;
        @(posedge ref_clk_in);
        watchdog_base_tick_in <= 1'h0;
        @(posedge ref_clk_in);
        check({31'h0, watchdog_tick_out}, {31'h0, exp}, "watchdog step");
    endtask

    task automatic test_reset();
        rd(TMRPS_OFS_OPTION, TMRPS_OPTION_RST, TMRPS_RESP_OKAY);
        rd(TMRPS_OFS_COUNT, TMRPS_COUNT_RST, TMRPS_RESP_OKAY);
        rd(5'h0c, 8'h00, TMRPS_RESP_SLVERR);
        wr(5'h10, 8'h55, TMRPS_RESP_SLVERR);
        // Low byte lane off: the count write is ignored
        wstrb_in <= 4'he;
        wr(TMRPS_OFS_COUNT, 8'h55, TMRPS_RESP_OKAY);
        wstrb_in <= 4'hf;
        rd(TMRPS_OFS_COUNT, TMRPS_COUNT_RST, TMRPS_RESP_OKAY);
        $display("reset test done");
    endtask

    // Inhibit after write, rollover flag, mask, every ratio
    task automatic test_timer();
        run_timer(8'h08, 8'hf0, 66, 80);
        rd(TMRPS_OFS_INTCTL, 8'h24, TMRPS_RESP_OKAY);
        wr(TMRPS_OFS_INTCTL, 8'h04, TMRPS_RESP_OKAY);
        @(posedge ref_clk_in);
        check({31'h0, overflow_irq_out}, 32'h0, "masked request");
        for (int i = 0; i < 8; i++)
            run_timer({5'h00, i[2:0]}, 8'hfc, 14 * (2 << i) - 2,
                24 * (2 << i) + 12);
        $display("timer test done");
    endtask

    // Five toggles from low give three rises and two falls
    task automatic test_counter();
        for (int e = 0; e < 2; e++)
        begin
            wr(TMRPS_OFS_OPTION, {3'h1, e[0], 4'h8}, TMRPS_RESP_OKAY);
            wr(TMRPS_OFS_COUNT, 8'h10, TMRPS_RESP_OKAY);
            repeat (12) @(posedge ref_clk_in);
            pulses(4'h5);
            rd(TMRPS_OFS_COUNT, e ? 8'h12 : 8'h13, TMRPS_RESP_OKAY);
            pulses(4'h1);
        end
        sleep_in <= 1'h1;
        wr(TMRPS_OFS_COUNT, 8'h40, TMRPS_RESP_OKAY);
        pulses(4'h2);
        rd(TMRPS_OFS_COUNT, 8'h40, TMRPS_RESP_OKAY);
        sleep_in <= 1'h0;
        $display("counter test done");
    endtask

    // Safe moves both ways; a clear restarts the watchdog's divide-by-two
    task automatic test_watchdog();
        clr_wdt();
        wr(TMRPS_OFS_OPTION, 8'h00, TMRPS_RESP_OKAY);
        wd_tick(1'h1);
        clr_wdt();
        wr(TMRPS_OFS_COUNT, 8'h00, TMRPS_RESP_OKAY);
        wr(TMRPS_OFS_OPTION, 8'h0f, TMRPS_RESP_OKAY);
        clr_wdt();
        wr(TMRPS_OFS_OPTION, 8'h08, TMRPS_RESP_OKAY);
        wd_tick(1'h0);
        clr_wdt();
        wd_tick(1'h0);
        wd_tick(1'h1);
        $display("watchdog test done");
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk_in);
        nrst_in <= 1'h1;
        test_reset();
        test_timer();
        test_counter();
        test_watchdog();
        summarize();
    end
endmodule

/* tmrps_pin_src.sv */
/* Pin source model: a burst of level toggles on the count pin.
   Assumes go_in is a one-cycle pulse on the core clock. */
`timescale 1ns/1ps
module tmrps_pin_src
(
    input wire logic ref_clk_in,
    input wire logic go_in,
    input wire logic [3:0] toggles_in,
    output logic pin_out
);
    localparam int HALF = 3;
    int left = 0;
    int cnt = 0;

    initial pin_out = 1'h0;

    // Each level held three clocks: above the two-period minimum, period six
    always @(posedge ref_clk_in)
    begin
        if (go_in)
            left <= int'(toggles_in);
        else if (left > 0 && cnt == HALF - 1)
        begin
            pin_out <= ~pin_out;
            left <= left - 1;
        end
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    end
endmodule

/* tmrps_pkg.sv */
/*
 * Shared constants and types for the 8-bit timer with shared prescaler.
 * Assumes a 20 MHz core clock with four phase clocks per instruction cycle.
 */
package tmrps_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [4:0] TMRPS_OFS_OPTION = 5'h00;
    localparam logic [4:0] TMRPS_OFS_COUNT = 5'h04;
    localparam logic [4:0] TMRPS_OFS_INTCTL = 5'h08;
    // Field positions in option and interrupt control registers
    localparam int TMRPS_BIT_SRC = 5;
    localparam int TMRPS_BIT_EDGE = 4;
    localparam int TMRPS_BIT_ASSIGN = 3;
    localparam int TMRPS_BIT_IRQ_EN = 5;
    localparam int TMRPS_BIT_OVF_FLAG = 2;
    // Values after reset
    localparam logic [7:0] TMRPS_OPTION_RST = 8'hff;
    localparam logic [7:0] TMRPS_COUNT_RST = 8'h00;
    localparam logic [7:0] TMRPS_INTCTL_RST = 8'h00;
    // Write inhibit in instruction cycles; count register maximum
    localparam logic [1:0] TMRPS_WR_INHIBIT_CYC = 2'h2;
    localparam logic [7:0] TMRPS_COUNT_MAX = 8'hff;
    // AXI response codes
    localparam logic [1:0] TMRPS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TMRPS_RESP_SLVERR = 2'h2;

    // Phase clocks of one instruction cycle
    typedef enum logic [3:0]
    {
        TMRPS_PH_Q1 = 4'b0001,
        TMRPS_PH_Q2 = 4'b0010,
        TMRPS_PH_Q3 = 4'b0100,
        TMRPS_PH_Q4 = 4'b1000
    } tmrps_phase_t;

    // Option register layout
    typedef struct packed
    {
        logic [1:0] unused;
        logic count_source_select;
        logic count_edge_select;
        logic prescaler_assign;
        logic [2:0] prescale_ratio_field;
    } tmrps_option_t;

    // Register select decoded from an address
    typedef enum logic [3:0]
    {
        TMRPS_SEL_NONE = 4'b0001,
        TMRPS_SEL_OPTION = 4'b0010,
        TMRPS_SEL_COUNT = 4'b0100,
        TMRPS_SEL_INTCTL = 4'b1000
    } tmrps_sel_t;
endpackage

/* tmrps_prescaler.sv */
/*
 * Shared 8-bit prescaler counter with a selectable tap.
 * Assumes single-cycle source ticks on the core clock; clear has priority.
 */
`timescale 1ns/1ps
module tmrps_prescaler
    import tmrps_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire logic src_tick_in,
    input wire logic bypass_in,
    input wire logic [2:0] ratio_in,
    output logic tick_out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] tap_mask;
    logic carry_at_tap;

    // Tap mask: bits 0..ratio must all be ones for the carry
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_mask
            assign tap_mask[gi] = (3'(gi) <= ratio_in) || (gi == 0);
        end
    endgenerate

    // Division by two to the power ratio plus one
    assign carry_at_tap = &(cnt_q | ~tap_mask);
    assign tick_out = bypass_in ? src_tick_in : (src_tick_in & carry_at_tap);
    assign cnt_d = clear_in ? 8'h00 : (src_tick_in ? cnt_q + 8'h01 : cnt_q);

    // Counter has no load path and no read path
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_d;
    end
endmodule

/* tmrps_properties.sv */
/* Port checker for tmrps_top: bus handshakes and tick causes.
   Bound to every tmrps_top instance; sees its ports only. */
`timescale 1ns/1ps
module tmrps_properties
    import tmrps_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic awvalid_in,
    input wire logic awready_out,
    input wire logic wvalid_in,
    input wire logic wready_out,
    input wire logic [1:0] bresp_out,
    input wire logic bvalid_out,
    input wire logic bready_in,
    input wire logic arvalid_in,
    input wire logic arready_out,
    input wire logic [31:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic rready_in,
    input wire logic watchdog_base_tick_in,
    input wire logic watchdog_tick_out,
    input wire logic overflow_irq_out
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    // Bus answers and holds
    // Both held first, response raised one edge after that
    AST_B_FOLLOWS: assert property (awvalid_in && awready_out && wvalid_in && wready_out
        |-> ##2 bvalid_out) else $error("no write response");
    AST_B_HOLDS: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("write response dropped");
    AST_R_FOLLOWS: assert property (arvalid_in && arready_out |=> rvalid_out)
        else $error("no read response");
    AST_R_HOLDS: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
        else $error("read data dropped");
    AST_AW_REFUSED: assert property (bvalid_out |-> !awready_out && !wready_out)
        else $error("write taken during response");
    AST_AW_GAP: assert property (awvalid_in && awready_out |=> !awready_out)
        else $error("address ready without gap");
    // Only the low byte carries state; the prescaler never shows
    AST_RDATA_UPPER: assert property (rvalid_out |-> rdata_out[31:8] == 24'h0)
        else $error("upper read bits set");
    // A watchdog step always has a base tick one cycle before
    AST_WDT_CAUSE: assert property (watchdog_tick_out
        |-> $past(watchdog_base_tick_in))
        else $error("watchdog step without tick");

    COV_WRITE: cover property (bvalid_out && bready_in);
    COV_READ: cover property (rvalid_out && rready_in);
    COV_IRQ: cover property ($rose(overflow_irq_out));
    COV_WDT: cover property (watchdog_tick_out);
endmodule

bind tmrps_top tmrps_properties tmrps_properties_inst (.*);

/* tmrps_top.sv */
/*
 * 8-bit timer/counter with a prescaler shared with the watchdog, AXI4-Lite slave.
 * Assumes the core clock is the oscillator; the watchdog counter sits outside and
 * supplies its own time base tick and clear-watchdog instruction pulse.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
// Notes on behaviour
// - Source bit clear selects instruction-cycle timer
// - Unprescaled timer adds one per instruction cycle
// - Count write blocks incrementing for two cycles
// - Source bit set counts pin edges, selectable
// - Assign bit clear: timer; set: watchdog
// - Timer ratios 1:2 through 1:256
// - Prescaler neither readable nor writable
// - One prescaler, serving exactly one user
// - Rollover FFh to 00h sets overflow flag
// - Interrupt request only while enable set
// - Timer halted during sleep
// - Pin sampled on second and fourth phase
// - Count write clears prescaler when timer-assigned
// - Clear-watchdog clears prescaler when watchdog-assigned
`timescale 1ns/1ps
module tmrps_top
    import tmrps_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [4:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [4:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic count_input_pin_in,
    input wire logic sleep_in,
    input wire logic clear_watchdog_in,
    input wire logic watchdog_base_tick_in,
    output logic watchdog_tick_out,
    output logic overflow_irq_out
);
    // Address decode shared by read and write paths
    function automatic tmrps_sel_t reg_sel(input logic [4:0] addr);
        if (addr == TMRPS_OFS_OPTION)
            return TMRPS_SEL_OPTION;
        else if (addr == TMRPS_OFS_COUNT)
            return TMRPS_SEL_COUNT;
        else if (addr == TMRPS_OFS_INTCTL)
            return TMRPS_SEL_INTCTL;
        else
            return TMRPS_SEL_NONE;
    endfunction

    tmrps_phase_t phase_q;
    tmrps_phase_t phase_d;
    tmrps_option_t option_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] intctl_q;
    logic [7:0] intctl_d;
    logic [1:0] inhibit_q;
    logic [1:0] inhibit_d;
    logic [2:0] pin_sync_q;
    logic pin_smp_q;
    logic aw_held_q;
    logic w_held_q;
    logic [4:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wdt_tick_q;
    logic irq_q;

    // Phase sequencer: instruction cycle is four oscillator clocks
    always_comb
    begin
        unique case (phase_q)
            TMRPS_PH_Q1: phase_d = TMRPS_PH_Q2;
            TMRPS_PH_Q2: phase_d = TMRPS_PH_Q3;
            TMRPS_PH_Q3: phase_d = TMRPS_PH_Q4;
            TMRPS_PH_Q4: phase_d = TMRPS_PH_Q1;
            default: phase_d = TMRPS_PH_Q1;
        endcase
    end

    wire instr_tick = (phase_q == TMRPS_PH_Q4);
    wire sample_phase = (phase_q == TMRPS_PH_Q2) || (phase_q == TMRPS_PH_Q4);

    // Pin sampled only on Q2/Q4 once the last two sync stages agree
    wire pin_stable = (pin_sync_q[1] == pin_sync_q[2]);
    wire pin_take = sample_phase && pin_stable;
    wire pin_rise = pin_take && pin_sync_q[2] && !pin_smp_q;
    wire pin_fall = pin_take && !pin_sync_q[2] && pin_smp_q;
    wire pin_edge = option_q.count_edge_select ? pin_fall : pin_rise;

    // Source selection, halted in sleep so no overflow can wake the core
    wire src_raw = option_q.count_source_select ? pin_edge : instr_tick;
    wire timer_src = src_raw && !sleep_in;

    // Write path decode
    wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
    wire tmrps_sel_t wr_sel = reg_sel(awaddr_q);
    wire wr_lane0 = wr_fire && wstrb_q[0];
    wire wr_option = wr_lane0 && (wr_sel == TMRPS_SEL_OPTION);
    wire wr_count = wr_lane0 && (wr_sel == TMRPS_SEL_COUNT);
    wire wr_intctl = wr_lane0 && (wr_sel == TMRPS_SEL_INTCTL);
    wire tmrps_sel_t rd_sel = reg_sel(araddr_in);

    // Exclusive assignment of the single prescaler
    wire to_timer = !option_q.prescaler_assign;
    wire psc_src = to_timer ? timer_src : watchdog_base_tick_in;
    wire psc_clear = to_timer ? wr_count : clear_watchdog_in;
    logic psc_tick;

    // Ratio and assignment read live each cycle
    tmrps_prescaler u_psc
    (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .clear_in(psc_clear),
        .src_tick_in(psc_src),
        .bypass_in(1'b0),
        .ratio_in(option_q.prescale_ratio_field),
        .tick_out(psc_tick)
    );

    // Unused user gets its source straight through
    wire timer_step = to_timer ? psc_tick : timer_src;
    wire wdt_step = to_timer ? watchdog_base_tick_in : psc_tick;

    // Count register with write inhibit window
    wire count_inc = timer_step && (inhibit_q == 2'h0) && !wr_count;
    wire overflow = count_inc && (count_q == TMRPS_COUNT_MAX);
    assign count_d = wr_count ? wdata_q[7:0] : (count_inc ? count_q + 8'h01 : count_q);

    // Inhibit counts down on instruction cycles
    always_comb
    begin
        inhibit_d = inhibit_q;
        if (wr_count)
            inhibit_d = TMRPS_WR_INHIBIT_CYC;
        else if (instr_tick && inhibit_q != 2'h0)
            inhibit_d = inhibit_q - 2'h1;
    end

    // Overflow set wins over a software clear in the same cycle
    always_comb
    begin
        intctl_d = wr_intctl ? wdata_q[7:0] : intctl_q;
        if (overflow)
            intctl_d[TMRPS_BIT_OVF_FLAG] = 1'b1;
    end

    // Timer state and phase
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            phase_q <= TMRPS_PH_Q1;
            count_q <= TMRPS_COUNT_RST;
            intctl_q <= TMRPS_INTCTL_RST;
            inhibit_q <= 2'h0;
            option_q <= TMRPS_OPTION_RST;
        end
        else
        begin
            phase_q <= phase_d;
            count_q <= count_d;
            intctl_q <= intctl_d;
            inhibit_q <= inhibit_d;
            if (wr_option)
                option_q <= wdata_q[7:0];
        end
    end

    // Three-stage pin synchroniser and phase-qualified sample
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_sync_q <= 3'h0;
            pin_smp_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], count_input_pin_in};
            if (pin_take)
                pin_smp_q <= pin_sync_q[2];
        end
    end

    // Registered outputs; request follows flag and enable one cycle later
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wdt_tick_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            wdt_tick_q <= wdt_step;
            irq_q <= intctl_q[TMRPS_BIT_IRQ_EN] && intctl_q[TMRPS_BIT_OVF_FLAG];
        end
    end

    // Write channels taken in either order, one write in flight
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= TMRPS_RESP_OKAY;
        end
        else
        begin
            awready_q <= !aw_held_q && !(awvalid_in && awready_q) && !bvalid_q;
            wready_q <= !w_held_q && !(wvalid_in && wready_q) && !bvalid_q;
            if (awvalid_in && awready_q)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= awaddr_in;
            end
            if (wvalid_in && wready_q)
            begin
                w_held_q <= 1'b1;
                wdata_q <= wdata_in;
                wstrb_q <= wstrb_in;
            end
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_sel == TMRPS_SEL_NONE) ? TMRPS_RESP_SLVERR : TMRPS_RESP_OKAY;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
            else if (bvalid_q && bready_in)
                bvalid_q <= 1'b0;
        end
    end

    // Read channel; the prescaler count has no read path
    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= TMRPS_RESP_OKAY;
        end
        else
        begin
            arready_q <= !rvalid_q && !(arvalid_in && arready_q);
            if (arvalid_in && arready_q)
            begin
                rvalid_q <= 1'b1;
                rresp_q <= (rd_sel == TMRPS_SEL_NONE) ? TMRPS_RESP_SLVERR : TMRPS_RESP_OKAY;
                unique case (rd_sel)
                    TMRPS_SEL_OPTION: rdata_q <= {24'h000000, option_q};
                    TMRPS_SEL_COUNT: rdata_q <= {24'h000000, count_q};
                    TMRPS_SEL_INTCTL: rdata_q <= {24'h000000, intctl_q};
                    TMRPS_SEL_NONE: rdata_q <= 32'h0000_0000;
                endcase
            end
            else if (rvalid_q && rready_in)
                rvalid_q <= 1'b0;
        end
    end

    assign awready_out = awready_q;
    assign wready_out = wready_q;
    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;
    assign arready_out = arready_q;
    assign rvalid_out = rvalid_q;
    assign rdata_out = rdata_q;
    assign rresp_out = rresp_q;
    assign watchdog_tick_out = wdt_tick_q;
    assign overflow_irq_out = irq_q;
endmodule
